// ### rtl/clo_current_loop_ctrl.sv
// Setpoint control for a 4-20 mA current-loop output
//
// Operation
// - Output mode codes: 0 off, 3 linear, 4 bilinear, 5 fixed; others unsupported.
// - Mode off drives a zero setpoint and stops conversion.
// - Linear and bilinear scale the latest selected result between low and high.
// - Fixed mode holds the written fixed current regardless of results.
// - Bilinear uses two segments meeting at the mid value, which gives 12 mA.
// - Error modes: 0 off, 1/2 alternating, 3/4 continuous; 2 and 4 add warnings.
// - Alternating overlay adds +/-0.5 mA square wave, 8 s period, 12 cycles.
// - After each burst the plain setpoint is output for 288 s.
// - After the plain interval a new burst starts if the condition persists.
// - The base setpoint keeps tracking new results during the 384 s cycle.
// - Continuous modes hold the error or warning level while active.
// - In continuous modes the error level wins over the warning level.
// - Linear maps low to 4 mA and high to 20 mA, interpolating between.
// - Results below low clamp to 4 mA, above high clamp to 20 mA.
// - Channel code 0001 selects oxygen, 0002 selects temperature.
`timescale 1ns/1ns
module clo_current_loop_ctrl
  import clo_pkg::*;
#(
  parameter int CYC_PER_SEC = CYC_PER_SEC_DEF,
  parameter int VAL_W = 24
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] out_mode,
  input wire logic [15:0] err_mode,
  input wire logic [15:0] chan_sel,
  input wire logic signed [VAL_W-1:0] range_low,
  input wire logic signed [VAL_W-1:0] range_mid,
  input wire logic signed [VAL_W-1:0] range_high,
  input wire logic [SP_W-1:0] fixed_current,
  input wire logic [SP_W-1:0] err_level,
  input wire logic err_level_we,
  input wire logic [SP_W-1:0] warn_level,
  input wire logic warn_level_we,
  input wire logic signed [VAL_W-1:0] oxy_value,
  input wire logic signed [VAL_W-1:0] temp_value,
  input wire logic result_valid,
  input wire logic err_active,
  input wire logic warn_active,
  output logic [SP_W-1:0] setpoint,
  output logic mode_supported,
  output logic burst_active,
  output logic conv_busy
);

  localparam int DIV_W = VAL_W + SP_W + 4;
  localparam int TICK_W = $clog2(CYC_PER_SEC);
  localparam logic [8:0] SEC_HALF_LAST = 9'(SQ_HALF_S - 1);
  localparam logic [8:0] SEC_PLAIN_LAST = 9'(PLAIN_S - 1);
  localparam logic [4:0] HALF_LAST = 5'(SQ_HALVES - 1);

  // ==========================================================================
  // Elaboration checks
  if (CYC_PER_SEC < 2 || VAL_W < 2 || ALT_CYCLE_S != SQ_CYCLES * SQ_PERIOD_S + PLAIN_S)
  begin : g_bad_cfg
    $error("clo_current_loop_ctrl: unusable parameter values");
  end

  // ==========================================================================
  // Result capture and settings
  logic signed [VAL_W-1:0] oxy_q, temp_q;
  logic [SP_W-1:0] err_lvl_q, warn_lvl_q;
  logic [16+16+3*VAL_W-1:0] cfg_q, cfg_now;
  logic is_conv_mode, chan_ok;
  // Latest result of each quantity is kept so a channel switch reconverts at once
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oxy_q <= '0;
      temp_q <= '0;
    end
    else if (result_valid)
    begin
      oxy_q <= oxy_value;
      temp_q <= temp_value;
    end
  end
  // Signalling levels start at their default values until written
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_lvl_q <= SP_ERR_DEF;
      warn_lvl_q <= SP_WARN_DEF;
    end
    else
    begin
      if (err_level_we)
        err_lvl_q <= err_level;
      if (warn_level_we)
        warn_lvl_q <= warn_level;
    end
  end
  // Any change of mode, channel or range reconverts, so a mode switch refreshes the base once that conversion ends
  assign cfg_now = {out_mode, chan_sel, range_low, range_mid, range_high};
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= '0;
    else
      cfg_q <= cfg_now;
  end
  assign is_conv_mode = (out_mode == OMODE_LIN) || (out_mode == OMODE_BIL);
  assign chan_ok = (chan_sel == CHAN_OXY) || (chan_sel == CHAN_TEMP);
  assign mode_supported = is_conv_mode || (out_mode == OMODE_OFF) || (out_mode == OMODE_FIX);

  // ==========================================================================
  // Range scaling plan for the current result
  logic signed [VAL_W-1:0] x_sel;
  logic signed [VAL_W:0] seg_lo, seg_hi, num_diff, den_diff;
  logic direct;
  logic [SP_W-1:0] direct_val, seg_off, seg_span;
  logic [DIV_W-1:0] div_num, div_den;

  always_comb
  begin
    x_sel = (chan_sel == CHAN_TEMP) ? temp_q : oxy_q;
    direct = 1'b0;
    direct_val = SP_4MA;
    seg_off = SP_4MA;
    seg_span = SP_SPAN_LIN;
    seg_lo = (VAL_W+1)'(range_low);
    seg_hi = (VAL_W+1)'(range_high);
    if (x_sel <= range_low)
    begin
      direct = 1'b1;
      direct_val = SP_4MA;
    end
    else if (x_sel >= range_high)
    begin
      direct = 1'b1;
      direct_val = SP_20MA;
    end
    else if (out_mode == OMODE_BIL)
    begin
      seg_span = SP_SPAN_BIL;
      if (x_sel < range_mid)
        seg_hi = (VAL_W+1)'(range_mid);
      else
      begin
        seg_lo = (VAL_W+1)'(range_mid);
        seg_off = SP_12MA;
      end
    end
    num_diff = (VAL_W+1)'(x_sel) - seg_lo;
    den_diff = seg_hi - seg_lo;
    div_num = DIV_W'(num_diff[VAL_W-1:0]) * DIV_W'(seg_span);
    div_den = DIV_W'(den_diff[VAL_W-1:0]);
  end

  // ==========================================================================
  // Conversion sequencing and the base setpoint
  logic pend_q, conv_start, div_busy, div_done;
  logic [DIV_W-1:0] div_quo;
  logic [SP_W-1:0] off_q, base_q;

  // Off and fixed modes never start a conversion
  assign conv_start = pend_q && !div_busy && is_conv_mode && chan_ok;
  // A new trigger in the start cycle keeps the request pending
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_q <= 1'b0;
    else
      pend_q <= result_valid || (cfg_q != cfg_now) || (pend_q && !conv_start);
  end
  // A fresh direct clamp is newer than a divider result finishing alongside it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      off_q <= SP_4MA;
      base_q <= SP_4MA;
    end
    else if (conv_start)
    begin
      off_q <= seg_off;
      if (direct)
        base_q <= direct_val;
    end
    else if (div_done)
      base_q <= off_q + div_quo[SP_W-1:0];
  end
  // Clamped results skip the divider and land at once
  clo_divider #(.W(DIV_W)) u_div (
    .core_clk(core_clk), .rst_n(rst_n), .start(conv_start && !direct),
    .dividend(div_num), .divisor(div_den),
    .busy(div_busy), .done(div_done), .quotient(div_quo)
  );
  assign conv_busy = pend_q || div_busy;

  // ==========================================================================
  // Alternating overlay scheduler on a seconds time base
  clo_alt_e alt_q;
  logic [TICK_W-1:0] tick_q;
  logic [8:0] sec_q;
  logic [4:0] half_q;
  logic tick, alt_en, alt_cond;

  assign alt_en = (err_mode == EMODE_ALT_E) || (err_mode == EMODE_ALT_EW);
  assign alt_cond = err_active || ((err_mode == EMODE_ALT_EW) && warn_active);
  assign tick = (tick_q == TICK_W'(CYC_PER_SEC - 1));
  // Seconds prescaler restarts in idle so a burst starts on a whole second
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_q <= '0;
    else
      tick_q <= (alt_q == ALT_IDLE || tick) ? '0 : tick_q + 1'b1;
  end
  // A started burst runs its full twelve cycles unless the error mode leaves alternating; idle clears the counters before a burst from idle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alt_q <= ALT_IDLE;
      sec_q <= '0;
      half_q <= '0;
    end
    else if (!alt_en)
      alt_q <= ALT_IDLE;
    else
    begin
      unique case (alt_q)
        ALT_IDLE:
        begin
          sec_q <= '0;
          half_q <= '0;
          if (alt_cond)
            alt_q <= ALT_BURST;
        end
        ALT_BURST:
          if (tick)
          begin
            if (sec_q == SEC_HALF_LAST)
            begin
              sec_q <= '0;
              half_q <= half_q + 1'b1;
              if (half_q == HALF_LAST)
              begin
                half_q <= '0;
                alt_q <= ALT_PLAIN;
              end
            end
            else
              sec_q <= sec_q + 1'b1;
          end
        ALT_PLAIN:
          if (tick)
          begin
            if (sec_q == SEC_PLAIN_LAST)
            begin
              sec_q <= '0;
              alt_q <= alt_cond ? ALT_BURST : ALT_IDLE;
            end
            else
              sec_q <= sec_q + 1'b1;
          end
        default:
          alt_q <= ALT_IDLE;
      endcase
    end
  end
  assign burst_active = (alt_q == ALT_BURST);

  // ==========================================================================
  // Final setpoint selection
  logic [SP_W-1:0] setpoint_d, setpoint_q;
  always_comb
  begin
    setpoint_d = SP_ZERO;
    unique case (out_mode)
      OMODE_OFF: setpoint_d = SP_ZERO;
      OMODE_FIX: setpoint_d = fixed_current;
      OMODE_LIN, OMODE_BIL:
      begin
        setpoint_d = base_q;
        if ((err_mode == EMODE_CONT_E || err_mode == EMODE_CONT_EW) && err_active)
          setpoint_d = err_lvl_q;
        else if (err_mode == EMODE_CONT_EW && warn_active)
          setpoint_d = warn_lvl_q;
        else if (alt_q == ALT_BURST)
          setpoint_d = half_q[0] ? base_q - SP_SQ_AMP : base_q + SP_SQ_AMP;
      end
      default: setpoint_d = SP_ZERO;
    endcase
  end
  // Registered so the converter stage never sees a decode glitch
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      setpoint_q <= SP_ZERO;
    else
      setpoint_q <= setpoint_d;
  end
  assign setpoint = setpoint_q;

  // ==========================================================================
  // Assertions and covers
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_off_zero: assert property ((out_mode == OMODE_OFF) |=> (setpoint == SP_ZERO))
    else $error("setpoint not zero in off mode");
  a_unsup_zero: assert property (!mode_supported |=> (setpoint == SP_ZERO))
    else $error("unsupported mode drives current");
  a_fixed_hold: assert property ((out_mode == OMODE_FIX) |=> (setpoint == $past(fixed_current)))
    else $error("fixed mode does not follow fixed current");
  a_err_level: assert property ((is_conv_mode && err_mode == EMODE_CONT_E && err_active)
    |=> (setpoint == $past(err_lvl_q)))
    else $error("continuous error level missing");
  a_err_priority: assert property ((is_conv_mode && err_mode == EMODE_CONT_EW && err_active && warn_active)
    |=> (setpoint == $past(err_lvl_q) && setpoint != $past(warn_lvl_q) || $past(err_lvl_q) == $past(warn_lvl_q)))
    else $error("warning level beat error level");
  a_warn_level: assert property ((is_conv_mode && err_mode == EMODE_CONT_E && warn_active && !err_active
    && alt_q == ALT_IDLE) |=> (setpoint == $past(base_q)))
    else $error("warning signalled in error-only mode");
  a_base_range: assert property ((base_q >= SP_4MA) && (base_q <= SP_20MA))
    else $error("base setpoint outside 4-20 mA");
  a_burst_len: assert property ((alt_q == ALT_BURST ##1 alt_q == ALT_PLAIN)
    |-> ($past(half_q) == HALF_LAST && $past(sec_q) == SEC_HALF_LAST))
    else $error("burst length wrong");
  a_plain_len: assert property ((alt_q == ALT_PLAIN ##1 alt_q != ALT_PLAIN && alt_en)
    |-> ($past(sec_q) == SEC_PLAIN_LAST))
    else $error("plain interval length wrong");
  a_burst_amp: assert property ((out_mode == OMODE_LIN && err_mode == EMODE_ALT_E
    && alt_q == ALT_BURST && !half_q[0]) |=> (setpoint == $past(base_q) + SP_SQ_AMP))
    else $error("square wave high half wrong");
  c_burst_entry: cover property (alt_q == ALT_IDLE ##1 alt_q == ALT_BURST);
  c_reburst: cover property (alt_q == ALT_PLAIN ##1 alt_q == ALT_BURST);
  c_bil_result: cover property (out_mode == OMODE_BIL && div_done);
  c_cont_warn: cover property (err_mode == EMODE_CONT_EW && warn_active && !err_active && is_conv_mode);

endmodule : clo_current_loop_ctrl

// ### rtl/clo_divider.sv
// Sequential restoring divider used for the range scaling
`timescale 1ns/1ns
module clo_divider
  import clo_pkg::*;
#(
  parameter int W = 40
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient
);

  // ==========================================================================
  // Elaboration check
  if (W < 2)
  begin : g_bad_w
    $error("clo_divider: W must be at least 2");
  end

  logic [W:0] rem_q;
  logic [W-1:0] quo_q;
  logic [W-1:0] den_q;
  logic [$clog2(W+1)-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [W:0] trial;

  // Trial subtraction of the shifted remainder
  assign trial = {rem_q[W-1:0], quo_q[W-1]} - {1'b0, den_q};

  // ==========================================================================
  // One quotient bit per clock; W clocks per division
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        rem_q <= '0;
        quo_q <= dividend;
        den_q <= divisor;
        cnt_q <= ($clog2(W+1))'(W);
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (!trial[W])
        begin
          rem_q <= trial;
          quo_q <= {quo_q[W-2:0], 1'b1};
        end
        else
        begin
          rem_q <= {rem_q[W-1:0], quo_q[W-1]};
          quo_q <= {quo_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign quotient = quo_q; // Holds until the next start

endmodule : clo_divider

// ### rtl/clo_pkg.sv
// Shared constants and types for the current-loop output control block
package clo_pkg;

  // ==========================================================================
  // Setpoint coding: unsigned, one LSB is 0.01 mA
  localparam int SP_W = 12;
  typedef logic [SP_W-1:0] clo_sp_t;
  localparam clo_sp_t SP_ZERO = 12'h000;
  localparam clo_sp_t SP_4MA = 12'h190;
  localparam clo_sp_t SP_12MA = 12'h4B0;
  localparam clo_sp_t SP_20MA = 12'h7D0;
  localparam clo_sp_t SP_SQ_AMP = 12'h032;
  localparam clo_sp_t SP_ERR_DEF = 12'h898;
  localparam clo_sp_t SP_WARN_DEF = 12'h834;
  localparam clo_sp_t SP_SPAN_LIN = SP_20MA - SP_4MA;
  localparam clo_sp_t SP_SPAN_BIL = SP_12MA - SP_4MA;

  // ==========================================================================
  // Setting codes
  localparam logic [15:0] OMODE_OFF = 16'h0000;
  localparam logic [15:0] OMODE_LIN = 16'h0003;
  localparam logic [15:0] OMODE_BIL = 16'h0004;
  localparam logic [15:0] OMODE_FIX = 16'h0005;
  localparam logic [15:0] EMODE_OFF = 16'h0000;
  localparam logic [15:0] EMODE_ALT_E = 16'h0001;
  localparam logic [15:0] EMODE_ALT_EW = 16'h0002;
  localparam logic [15:0] EMODE_CONT_E = 16'h0003;
  localparam logic [15:0] EMODE_CONT_EW = 16'h0004;
  localparam logic [15:0] CHAN_OXY = 16'h0001;
  localparam logic [15:0] CHAN_TEMP = 16'h0002;

  // ==========================================================================
  // Timing: clock rate and the alternating overlay schedule in seconds
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_NS = 1000000000;
  localparam int CYC_PER_SEC_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int SQ_PERIOD_S = 8;
  localparam int SQ_HALF_S = SQ_PERIOD_S / 2;
  localparam int SQ_CYCLES = 12;
  localparam int SQ_HALVES = 2 * SQ_CYCLES;
  localparam int PLAIN_S = 288;
  localparam int ALT_CYCLE_S = 384;

  // ==========================================================================
  // Overlay scheduler states, Gray along idle -> burst -> plain
  typedef enum logic [1:0]
  {
    ALT_IDLE = 2'b00,
    ALT_BURST = 2'b01,
    ALT_PLAIN = 2'b11
  } clo_alt_e;

endpackage : clo_pkg

// ### test/clo_current_loop_ctrl_tb_top.sv
// Self-checking bench for the current-loop output control block
`timescale 1ns/1ns
module clo_current_loop_ctrl_tb_top
  import clo_pkg::*;
;
  // ==========================================================================
  // Scaled second and range points shared by the bench model
  localparam int CPS = 4;
  localparam int LOW = 1000;
  localparam int MID = 15000;
  localparam int HIGH = 21000;
  logic core_clk;
  logic rst_n;
  logic [15:0] out_mode, err_mode, chan_sel;
  logic signed [23:0] range_low, range_mid, range_high, oxy_value, temp_value;
  logic [SP_W-1:0] fixed_current, err_level, warn_level, setpoint, reading_q;
  logic err_level_we, warn_level_we, result_valid, err_active, warn_active;
  logic mode_supported, burst_active, conv_busy, loop_dead;
  int miscompares, num_checks, cycle_cnt, v, w, b, t0, n;
  int edge_v[5] = '{LOW, HIGH, LOW - 1, HIGH + 1, MID};
  int ems[3] = '{0, 3, 4};
  logic [15:0] lfsr;
  int exp_q[$];

  clo_current_loop_ctrl #(.CYC_PER_SEC(CPS), .VAL_W(24)) clo_current_loop_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .out_mode(out_mode), .err_mode(err_mode),
    .chan_sel(chan_sel), .range_low(range_low), .range_mid(range_mid), .range_high(range_high),
    .fixed_current(fixed_current), .err_level(err_level), .err_level_we(err_level_we),
    .warn_level(warn_level), .warn_level_we(warn_level_we), .oxy_value(oxy_value),
    .temp_value(temp_value), .result_valid(result_valid), .err_active(err_active),
    .warn_active(warn_active), .setpoint(setpoint), .mode_supported(mode_supported),
    .burst_active(burst_active), .conv_busy(conv_busy));

  clo_loop_receiver clo_loop_receiver_i (.core_clk(core_clk), .rst_n(rst_n), .setpoint(setpoint),
    .reading_q(reading_q), .loop_dead(loop_dead));

  // ==========================================================================
  // Clock and a free cycle count for the long overlay schedule
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    cycle_cnt <= cycle_cnt + 1;

  // ==========================================================================
  // Reference scaling; integer division truncates as the design does
  function automatic int model_sp(input int x, input logic [15:0] om);
    if (x <= LOW)
      return 400;
    if (x >= HIGH)
      return 2000;
    if (om == OMODE_LIN)
      return 400 + (x - LOW) * 1600 / (HIGH - LOW);
    if (x < MID)
      return 400 + (x - LOW) * 800 / (MID - LOW);
    return 1200 + (x - MID) * 800 / (HIGH - MID);
  endfunction : model_sp

  // Results spread past both range ends so clamping is exercised too
  function automatic int rnd_val();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return int'(lfsr % 16'd24000) - 1500;
  endfunction : rnd_val

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic check(input logic [SP_W-1:0] got, input int exp);
    num_checks++;
    if (got !== SP_W'(exp))
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, SP_W'(exp));
    end
  endtask : check

  // Inputs always move a fixed 2 ns after the rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : cyc

  // One result pulse, then a bounded wait until the setpoint has settled
  task automatic send(input int ox, input int tp);
    int k;
    oxy_value = 24'(ox);
    temp_value = 24'(tp);
    result_valid = 1'b1;
    cyc(1);
    result_valid = 1'b0;
    k = 0;
    cyc(2);
    while (conv_busy !== 1'b0 && k < 200)
    begin
      cyc(1);
      k++;
    end
    if (k >= 200)
    begin
      miscompares++;
      stop_test();
    end
    cyc(3);
  endtask : send

  // ==========================================================================
  // Main sequence
  initial
  begin
    {miscompares, num_checks} = '0;
    lfsr = 16'd61690;
    rst_n = 1'b0;
    {out_mode, err_mode} = '0;
    chan_sel = CHAN_OXY;
    range_low = 24'(LOW);
    range_mid = 24'(MID);
    range_high = 24'(HIGH);
    fixed_current = 12'h4D2;
    {err_level, warn_level, oxy_value, temp_value} = '0;
    {err_level_we, warn_level_we, result_valid, err_active, warn_active} = '0;
    cyc(10);
    check(setpoint, 0);
    rst_n = 1'b1;
    // Output mode codes 0 to 7, supported or not
    for (int c = 0; c < 8; c++)
    begin
      out_mode = 16'(c);
      cyc(3);
      check(mode_supported, (c == 0 || c == 3 || c == 4 || c == 5) ? 1 : 0);
      if (c == 5)
        check(setpoint, 12'h4D2);
      else if (c != 3 && c != 4)
        check(loop_dead, 1);
    end
    // Both scaling modes on both channels, edge values then random ones
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 2; c++)
        for (int i = 0; i < 8; i++)
        begin
          out_mode = m ? OMODE_BIL : OMODE_LIN;
          chan_sel = c ? CHAN_TEMP : CHAN_OXY;
          v = i < 5 ? edge_v[i] : rnd_val();
          w = rnd_val();
          exp_q.push_back(model_sp(v, out_mode));
          if (c)
            send(w, v);
          else
            send(v, w);
          check(setpoint, exp_q.pop_front());
        end
    // Continuous levels over every condition mix
    out_mode = OMODE_LIN;
    chan_sel = CHAN_OXY;
    send(LOW, 0);
    foreach (ems[e])
      for (int k = 0; k < 4; k++)
      begin
        err_mode = 16'(ems[e]);
        err_active = k[0];
        warn_active = k[1];
        cyc(2);
        check(setpoint, (k[0] && ems[e] != 0) ? 2200 : ((k[1] && ems[e] == 4) ? 2100 : 400));
      end
    warn_level = 12'h76C;
    warn_level_we = 1'b1;
    err_active = 1'b0;
    cyc(1);
    warn_level_we = 1'b0;
    cyc(2);
    check(setpoint, 12'h76C);
    // A warning alone must not start a burst in the errors-only mode
    err_mode = EMODE_ALT_E;
    cyc(4);
    check(burst_active, 0);
    warn_active = 1'b0;
    send(MID, 0);
    b = model_sp(MID, OMODE_LIN);
    err_active = 1'b1;
    n = 0;
    while (burst_active !== 1'b1 && n < 5)
    begin
      cyc(1);
      n++;
    end
    // A burst that never starts is a failure, not a silent skip
    if (burst_active !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    t0 = cycle_cnt;
    cyc(8);
    // Sample each 4 s half in its middle
    for (int h = 0; h < SQ_HALVES; h++)
    begin
      check(setpoint, h % 2 ? b - 50 : b + 50);
      cyc(4 * CPS);
    end
    check(burst_active, 0);
    check(setpoint, b);
    send(HIGH, 0);
    check(setpoint, 2000);
    while (cycle_cnt < t0 + 1530)
      cyc(1);
    check(burst_active, 0);
    cyc(14);
    check(burst_active, 1);
    check(setpoint, 2050);
    err_mode = EMODE_OFF;
    err_active = 1'b0;
    cyc(2);
    check(burst_active, 0);
    check(setpoint, 2000);
    stop_test();
  end
endmodule : clo_current_loop_ctrl_tb_top

// ### test/clo_loop_receiver.sv
// Behavioural current-loop receiver that reads the loop current on the far side
`timescale 1ns/1ns
module clo_loop_receiver
  import clo_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [SP_W-1:0] setpoint,
  output logic [SP_W-1:0] reading_q,
  output logic loop_dead
);
  // ==========================================================================
  // Loop current settles one sample after the setpoint changes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reading_q <= SP_ZERO;
    else
      reading_q <= setpoint;
  end

  // A zero reading looks like an unpowered or open loop to the controller
  assign loop_dead = (reading_q == SP_ZERO);
endmodule : clo_loop_receiver
